// >>> src/bfc_map.svh
// register offsets, field positions, reset values and decode constants of the forwarding control block
`ifndef BFC_MAP_SVH
`define BFC_MAP_SVH

`define BFC_OFF_CTL 5'h00
`define BFC_OFF_CMD 5'h04
`define BFC_OFF_STS 5'h08
`define BFC_OFF_CLR 5'h0C
`define BFC_OFF_IEN 5'h10

`define BFC_CTL_ISA 2
`define BFC_CTL_VGA 3
`define BFC_CTL_FULL 4
`define BFC_CTL_MAM 5
`define BFC_CMD_IO 0
`define BFC_CMD_MEM 1

`define BFC_CTL_RST 4'h0
`define BFC_CMD_RST 2'h0
`define BFC_STS_RST 4'h0
`define BFC_IEN_RST 4'h0

`define BFC_EV_MA 0
`define BFC_EV_UR 1
`define BFC_EV_DNBLK 2
`define BFC_EV_UPBLK 3

`define BFC_ABORT_DATA 32'hFFFF_FFFF
`define BFC_MEM_LO 32'h000A_0000
`define BFC_MEM_HI 32'h000B_FFFF
`define BFC_IO_A_LO 10'h3B0
`define BFC_IO_A_HI 10'h3BB
`define BFC_IO_B_LO 10'h3C0
`define BFC_IO_B_HI 10'h3DF
`define BFC_IO_UPPER 16'h0000
`define BFC_IO_ALIAS_FREE 2'h0
`define BFC_DISPLAY_HI 6'h00

`endif

// >>> src/bfc_pkg.sv
// types of the forwarding control block
package bfc_pkg;

  typedef struct packed {
    logic master_abort_reply_mode;
    logic full;
    logic vga;
    logic legacy_io_alias_block;
  } ctl_t;

  typedef struct packed {
    ctl_t ctl;
    logic [1:0] cmd;
    logic [3:0] sts;
    logic [3:0] ien;
    logic ack;
    logic [31:0] rdata;
    logic dn_done;
    logic dn_fwd;
    logic up_done;
    logic up_fwd;
    logic abt_done;
    logic [31:0] abt_rdata;
    logic ur_cpl;
    logic discard;
    logic err_sig;
    logic tgt_abort;
  } st_t;

endpackage

// >>> src/bridge_fwd_ctrl.sv
// forwarding decode and abort reply control of the bridge, with its Avalon-MM register slave
// Operation
// - mode clear: aborted reads return all ones, aborted writes are dropped silently
// - mode set: PCI master abort gives an unsupported request completion upstream
// - mode set: unsupported request completion from PCIe target-aborts the PCI cycle, unless a master abort comes in the same cycle
// - mode set also signals errors on master aborted posted writes
// - full decode clear ignores I/O bits 15:10; set includes them
// - full decode matters only while legacy display forwarding is enabled
// - display forwarding claims primary memory A0000h-BFFFFh and forwards downstream
// - display forwarding passes primary I/O ports 3B0h-3BBh, 3C0h-3DFh, upper half zero
// - display forwarding ignores alias block bit and all base/limit windows
// - display I/O needs I/O space enable, display memory needs memory space enable
// - display forwarding off: such addresses pass only inside a configured window
// - alias filtering applies only inside the I/O window and below 64 KB
// - alias block set: upper 768 bytes of each 1 KB not forwarded downstream
// - alias block set: upper 768 bytes of each 1 KB forwarded upstream
// - alias block clear: every I/O address in the window goes downstream while I/O space is enabled
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "bfc_map.svh"

module bridge_fwd_ctrl (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic DN_REQ,
  input wire logic DN_IO,
  input wire logic [31:0] DN_ADDR,
  input wire logic DN_IN_WIN,
  output logic DN_DONE,
  output logic DN_FWD,
  input wire logic UP_REQ,
  input wire logic UP_IO,
  input wire logic [31:0] UP_ADDR,
  input wire logic UP_IN_WIN,
  output logic UP_DONE,
  output logic UP_FWD,
  input wire logic MA_EVT,
  input wire logic MA_READ,
  input wire logic MA_POSTED,
  input wire logic UR_EVT,
  input wire logic UR_READ,
  output logic ABT_DONE,
  output logic [31:0] ABT_RDATA,
  output logic UR_CPL,
  output logic WR_DISCARD,
  output logic ERR_SIG,
  output logic TGT_ABORT,
  output logic IRQ
);

  bfc_pkg::st_t st_r;
  bfc_pkg::st_t st_nxt;

  function automatic logic disp_io_hit(input logic [31:0] a, input logic full);
    logic lo_ok;
    lo_ok = (a[9:0] >= `BFC_IO_A_LO && a[9:0] <= `BFC_IO_A_HI) ||
            (a[9:0] >= `BFC_IO_B_LO && a[9:0] <= `BFC_IO_B_HI);
    disp_io_hit = lo_ok && a[31:16] == `BFC_IO_UPPER &&
                  (!full || a[15:10] == `BFC_DISPLAY_HI);
  endfunction

  function automatic logic disp_mem_hit(input logic [31:0] a);
    disp_mem_hit = a >= `BFC_MEM_LO && a <= `BFC_MEM_HI;
  endfunction

  // upper 768 bytes of a 1 KB block inside the first 64 KB
  function automatic logic alias_hit(input logic [31:0] a);
    alias_hit = a[31:16] == `BFC_IO_UPPER && a[9:8] != `BFC_IO_ALIAS_FREE;
  endfunction

  logic acc;
  logic wr_ok;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic dn_disp;
  logic dn_alias_blk;
  logic up_disp;
  logic up_alias_fwd;

  assign acc = (AVS_READ || AVS_WRITE) && !st_r.ack;
  assign wr_ok = AVS_WRITE && st_r.ack && AVS_BYTEENABLE[0];

  always_comb begin
    st_nxt = st_r;
    ev_set = 4'h0;
    ev_clr = 4'h0;
    dn_disp = 1'b0;
    dn_alias_blk = 1'b0;
    up_disp = 1'b0;
    up_alias_fwd = 1'b0;

    // bus slave: one wait state, read data is sampled while ack is low, a write is taken while ack is high
    st_nxt.ack = acc;
    st_nxt.rdata = 32'h0000_0000;
    if (AVS_READ && !st_r.ack) begin
      unique case (AVS_ADDRESS)
        `BFC_OFF_CTL: begin
          st_nxt.rdata[`BFC_CTL_MAM] = st_r.ctl.master_abort_reply_mode;
          st_nxt.rdata[`BFC_CTL_FULL] = st_r.ctl.full;
          st_nxt.rdata[`BFC_CTL_VGA] = st_r.ctl.vga;
          st_nxt.rdata[`BFC_CTL_ISA] = st_r.ctl.legacy_io_alias_block;
        end
        `BFC_OFF_CMD: begin
          st_nxt.rdata[1:0] = st_r.cmd;
        end
        `BFC_OFF_STS: begin
          st_nxt.rdata[3:0] = st_r.sts;
        end
        `BFC_OFF_IEN: begin
          st_nxt.rdata[3:0] = st_r.ien;
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
    // writes land at the completing edge, so every decode begun after it sees them
    if (wr_ok) begin
      unique case (AVS_ADDRESS)
        `BFC_OFF_CTL: begin
          st_nxt.ctl.master_abort_reply_mode = AVS_WRITEDATA[`BFC_CTL_MAM];
          st_nxt.ctl.full = AVS_WRITEDATA[`BFC_CTL_FULL];
          st_nxt.ctl.vga = AVS_WRITEDATA[`BFC_CTL_VGA];
          st_nxt.ctl.legacy_io_alias_block = AVS_WRITEDATA[`BFC_CTL_ISA];
        end
        `BFC_OFF_CMD: begin
          st_nxt.cmd = AVS_WRITEDATA[1:0];
        end
        `BFC_OFF_CLR: begin
          ev_clr = AVS_WRITEDATA[3:0];
        end
        `BFC_OFF_IEN: begin
          st_nxt.ien = AVS_WRITEDATA[3:0];
        end
        default: begin
          ev_clr = 4'h0;
        end
      endcase
    end

    // downstream decode, primary to secondary
    st_nxt.dn_done = DN_REQ;
    st_nxt.dn_fwd = 1'b0;
    if (DN_REQ) begin
      if (DN_IO) begin
        dn_disp = st_r.ctl.vga && disp_io_hit(DN_ADDR, st_r.ctl.full);
        dn_alias_blk = st_r.ctl.legacy_io_alias_block && DN_IN_WIN && alias_hit(DN_ADDR);
        if (dn_disp) begin
          st_nxt.dn_fwd = st_r.cmd[`BFC_CMD_IO];
        end else begin
          st_nxt.dn_fwd = st_r.cmd[`BFC_CMD_IO] && DN_IN_WIN && !dn_alias_blk;
          ev_set[`BFC_EV_DNBLK] = dn_alias_blk;
        end
      end else begin
        dn_disp = st_r.ctl.vga && disp_mem_hit(DN_ADDR);
        if (dn_disp) begin
          st_nxt.dn_fwd = st_r.cmd[`BFC_CMD_MEM];
        end else begin
          st_nxt.dn_fwd = st_r.cmd[`BFC_CMD_MEM] && DN_IN_WIN;
        end
      end
    end

    // upstream decode, secondary to primary: inverse of the downstream windows
    st_nxt.up_done = UP_REQ;
    st_nxt.up_fwd = 1'b0;
    if (UP_REQ) begin
      if (UP_IO) begin
        up_disp = st_r.ctl.vga && disp_io_hit(UP_ADDR, st_r.ctl.full);
        up_alias_fwd = st_r.ctl.legacy_io_alias_block && UP_IN_WIN && alias_hit(UP_ADDR);
      end else begin
        up_disp = st_r.ctl.vga && disp_mem_hit(UP_ADDR);
      end
      if (up_disp) begin
        st_nxt.up_fwd = 1'b0;
        ev_set[`BFC_EV_UPBLK] = 1'b1;
      end else if (up_alias_fwd) begin
        st_nxt.up_fwd = 1'b1;
      end else begin
        st_nxt.up_fwd = !UP_IN_WIN;
      end
    end

    // abort replies
    st_nxt.abt_done = MA_EVT || UR_EVT;
    st_nxt.ur_cpl = 1'b0;
    st_nxt.discard = 1'b0;
    st_nxt.err_sig = 1'b0;
    st_nxt.tgt_abort = 1'b0;
    st_nxt.abt_rdata = 32'h0000_0000;
    if (MA_EVT) begin
      ev_set[`BFC_EV_MA] = 1'b1;
      if (st_r.ctl.master_abort_reply_mode) begin
        st_nxt.ur_cpl = 1'b1;
        st_nxt.err_sig = MA_POSTED && !MA_READ;
      end else if (MA_READ) begin
        st_nxt.abt_rdata = `BFC_ABORT_DATA;
      end else begin
        st_nxt.discard = 1'b1;
      end
    end else if (UR_EVT) begin
      ev_set[`BFC_EV_UR] = 1'b1;
      if (st_r.ctl.master_abort_reply_mode) begin
        st_nxt.tgt_abort = 1'b1;
      end else if (UR_READ) begin
        st_nxt.abt_rdata = `BFC_ABORT_DATA;
      end else begin
        st_nxt.discard = 1'b1;
      end
    end

    // an event in the cycle of its clear stays set
    st_nxt.sts = (st_r.sts & ~ev_clr) | ev_set;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r <= '0;
      st_r.ctl <= `BFC_CTL_RST;
      st_r.cmd <= `BFC_CMD_RST;
      st_r.sts <= `BFC_STS_RST;
      st_r.ien <= `BFC_IEN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !st_r.ack;
  assign AVS_READDATA = st_r.rdata;
  assign DN_DONE = st_r.dn_done;
  assign DN_FWD = st_r.dn_fwd;
  assign UP_DONE = st_r.up_done;
  assign UP_FWD = st_r.up_fwd;
  assign ABT_DONE = st_r.abt_done;
  assign ABT_RDATA = st_r.abt_rdata;
  assign UR_CPL = st_r.ur_cpl;
  assign WR_DISCARD = st_r.discard;
  assign ERR_SIG = st_r.err_sig;
  assign TGT_ABORT = st_r.tgt_abort;
  assign IRQ = |(st_r.sts & st_r.ien);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  abort_ones_a: assert property (
    MA_EVT && MA_READ && !st_r.ctl.master_abort_reply_mode |=> ABT_DONE && ABT_RDATA == 32'hFFFF_FFFF && !UR_CPL)
    else $error("aborted read did not return all ones");

  abort_drop_a: assert property (
    MA_EVT && !MA_READ && !st_r.ctl.master_abort_reply_mode |=> WR_DISCARD && !ERR_SIG && !UR_CPL)
    else $error("aborted write not dropped silently");

  ur_reply_a: assert property (
    MA_EVT && st_r.ctl.master_abort_reply_mode |=> UR_CPL && !WR_DISCARD)
    else $error("no unsupported request reply on master abort");

  target_abort_a: assert property (
    !MA_EVT && UR_EVT && st_r.ctl.master_abort_reply_mode ##1 !UR_EVT |-> TGT_ABORT ##1 !TGT_ABORT)
    else $error("target abort missing or not one cycle");

  posted_err_a: assert property (
    MA_EVT && MA_POSTED && !MA_READ |=> ERR_SIG == $past(st_r.ctl.master_abort_reply_mode))
    else $error("posted write error signalling wrong");

  alias_ignore_a: assert property (
    DN_REQ && DN_IO && st_r.ctl.vga && !st_r.ctl.full && st_r.cmd[0] &&
    DN_ADDR[31:16] == 16'h0000 && DN_ADDR[9:0] >= 10'h3C0 && DN_ADDR[9:0] <= 10'h3DF |=> DN_FWD)
    else $error("display alias not forwarded");

  full_decode_a: assert property (
    DN_REQ && DN_IO && st_r.ctl.vga && st_r.ctl.full && !DN_IN_WIN &&
    DN_ADDR[15:10] != 6'h00 |=> !DN_FWD)
    else $error("full decode forwarded aliased port");

  no_window_a: assert property (
    DN_REQ && !st_r.ctl.vga && !DN_IN_WIN |=> DN_DONE && !DN_FWD)
    else $error("forwarded outside window with display off");

  frame_mem_a: assert property (
    DN_REQ && !DN_IO && st_r.ctl.vga && st_r.cmd[1] &&
    DN_ADDR >= 32'h000A_0000 && DN_ADDR <= 32'h000B_FFFF |=> DN_FWD)
    else $error("frame buffer access not claimed");

  io_enable_a: assert property (
    DN_REQ && DN_IO && !st_r.cmd[0] |=> !DN_FWD)
    else $error("I/O forwarded with I/O space disabled");

  up_block_a: assert property (
    UP_REQ && !UP_IO && st_r.ctl.vga &&
    UP_ADDR >= 32'h000A_0000 && UP_ADDR <= 32'h000B_FFFF |=> UP_DONE && !UP_FWD)
    else $error("display memory forwarded upstream");

  dn_alias_a: assert property (
    DN_REQ && DN_IO && st_r.ctl.legacy_io_alias_block && !st_r.ctl.vga && DN_IN_WIN &&
    DN_ADDR[31:16] == 16'h0000 && DN_ADDR[9:8] != 2'h0 |=> !DN_FWD)
    else $error("alias block let upper bytes downstream");

  up_alias_a: assert property (
    UP_REQ && UP_IO && st_r.ctl.legacy_io_alias_block && !st_r.ctl.vga && UP_IN_WIN &&
    UP_ADDR[31:16] == 16'h0000 && UP_ADDR[9:8] != 2'h0 |=> UP_FWD)
    else $error("alias block did not forward upstream");

  window_pass_a: assert property (
    DN_REQ && DN_IO && !st_r.ctl.legacy_io_alias_block && !st_r.ctl.vga && DN_IN_WIN && st_r.cmd[0] |=> DN_FWD)
    else $error("in-window I/O not forwarded");

  ctl_update_a: assert property (
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00 && AVS_BYTEENABLE[0] |=>
    st_r.ctl.vga == $past(AVS_WRITEDATA[3]) && st_r.ctl.master_abort_reply_mode == $past(AVS_WRITEDATA[5]))
    else $error("control write not in force after completion");

  bus_answer_a: assert property (
    (AVS_READ || AVS_WRITE) |-> ##[0:1] !AVS_WAITREQUEST)
    else $error("slave did not answer within one wait state");

  ma_status_a: assert property (
    MA_EVT |=> st_r.sts[`BFC_EV_MA])
    else $error("master abort not recorded in status");

  ur_status_a: assert property (
    !MA_EVT && UR_EVT |=> st_r.sts[`BFC_EV_UR])
    else $error("unsupported request not recorded in status");

  sts_clear_a: assert property (
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `BFC_OFF_CLR && AVS_BYTEENABLE[0] &&
    AVS_WRITEDATA[`BFC_EV_MA] && !MA_EVT |=> !st_r.sts[`BFC_EV_MA])
    else $error("status bit not cleared by write");

  ctl_readback_a: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `BFC_OFF_CTL |-> AVS_READDATA[`BFC_CTL_MAM:`BFC_CTL_ISA] == st_r.ctl)
    else $error("control read data does not match the register");

  rdata_idle_a: assert property (
    !AVS_READ |-> AVS_READDATA == 32'h0000_0000)
    else $error("read data not cleared outside a read");

  dn_pulse_a: assert property (
    !DN_REQ |=> !DN_DONE && !DN_FWD)
    else $error("downstream result outside its cycle");

  up_pulse_a: assert property (
    !UP_REQ |=> !UP_DONE && !UP_FWD)
    else $error("upstream result outside its cycle");

  abt_quiet_a: assert property (
    !MA_EVT && !UR_EVT |=> !ABT_DONE && !UR_CPL && !WR_DISCARD && !ERR_SIG && !TGT_ABORT &&
    ABT_RDATA == 32'h0000_0000)
    else $error("abort reply without an abort event");

  ur_quiet_a: assert property (
    !MA_EVT && UR_EVT && !st_r.ctl.master_abort_reply_mode |=> !TGT_ABORT && !UR_CPL && !ERR_SIG)
    else $error("abort reported while reply mode is clear");

  full_display_a: assert property (
    DN_REQ && DN_IO && st_r.ctl.vga && st_r.ctl.full && st_r.cmd[`BFC_CMD_IO] &&
    DN_ADDR[31:16] == `BFC_IO_UPPER && DN_ADDR[15:10] == `BFC_DISPLAY_HI &&
    DN_ADDR[9:0] >= `BFC_IO_B_LO && DN_ADDR[9:0] <= `BFC_IO_B_HI |=> DN_FWD)
    else $error("fully decoded display port not forwarded");

  up_io_block_a: assert property (
    UP_REQ && UP_IO && st_r.ctl.vga && UP_ADDR[31:16] == `BFC_IO_UPPER && UP_ADDR[15:10] == `BFC_DISPLAY_HI &&
    UP_ADDR[9:0] >= `BFC_IO_B_LO && UP_ADDR[9:0] <= `BFC_IO_B_HI |=> !UP_FWD && st_r.sts[`BFC_EV_UPBLK])
    else $error("display port forwarded upstream");

  mem_enable_a: assert property (
    DN_REQ && !DN_IO && !st_r.cmd[`BFC_CMD_MEM] |=> !DN_FWD)
    else $error("memory forwarded with memory space disabled");

  dn_blk_status_a: assert property (
    DN_REQ && DN_IO && st_r.ctl.legacy_io_alias_block && !st_r.ctl.vga && DN_IN_WIN &&
    DN_ADDR[31:16] == `BFC_IO_UPPER && DN_ADDR[9:8] != `BFC_IO_ALIAS_FREE |=> st_r.sts[`BFC_EV_DNBLK])
    else $error("blocked alias not recorded in status");

endmodule

// >>> dv/pci_side_model.sv
// behavioural model of the secondary-side controller: upstream cycles and abort events
`timescale 1ns/10ps
module pci_side_model (
  input wire logic CLK,
  output logic UP_REQ,
  output logic UP_IO,
  output logic [31:0] UP_ADDR,
  output logic UP_IN_WIN,
  output logic MA_EVT,
  output logic MA_READ,
  output logic MA_POSTED,
  output logic UR_EVT,
  output logic UR_READ
);
  initial begin
    {UP_REQ, UP_IO, UP_IN_WIN, MA_EVT, MA_READ, MA_POSTED, UR_EVT, UR_READ} = 8'h00;
    UP_ADDR = 32'h5A5A_5A5A;
  end
  // one upstream decode request, address lines show the inverse once released
  task automatic up(input logic io, input logic [31:0] a, input logic win);
    @(posedge CLK);
    {UP_REQ, UP_IO, UP_ADDR, UP_IN_WIN} <= {1'b1, io, a, win};
    @(posedge CLK);
    {UP_REQ, UP_IO, UP_ADDR, UP_IN_WIN} <= {1'b0, ~io, ~a, ~win};
  endtask
  task automatic abt(input logic ma, input logic ur, input logic rd, input logic posted);
    @(posedge CLK);
    {MA_EVT, UR_EVT, MA_READ, UR_READ, MA_POSTED} <= {ma, ur, rd, rd, posted};
    @(posedge CLK);
    {MA_EVT, UR_EVT, MA_READ, UR_READ, MA_POSTED} <= 5'h00;
  endtask
endmodule

// >>> dv/test_bridge_fwd_ctrl.sv
// self-checking testbench of the forwarding control block
`timescale 1ns/10ps
module test_bridge_fwd_ctrl;
  logic CLK = 1'b0, RST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST, IRQ;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic [3:0] AVS_BYTEENABLE = 4'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA, DN_ADDR = 32'h0000_0000, UP_ADDR, ABT_RDATA;
  logic DN_REQ = 1'b0, DN_IO = 1'b0, DN_IN_WIN = 1'b0, DN_DONE, DN_FWD, UP_REQ, UP_IO, UP_IN_WIN, UP_DONE, UP_FWD;
  logic MA_EVT, MA_READ, MA_POSTED, UR_EVT, UR_READ, UR_CPL, WR_DISCARD, ERR_SIG, TGT_ABORT, ABT_DONE;
  int error_cnt = 0, n_tests = 0;
  bridge_fwd_ctrl i_bridge_fwd_ctrl (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .DN_REQ(DN_REQ), .DN_IO(DN_IO),
    .DN_ADDR(DN_ADDR), .DN_IN_WIN(DN_IN_WIN), .DN_DONE(DN_DONE), .DN_FWD(DN_FWD), .UP_REQ(UP_REQ),
    .UP_IO(UP_IO), .UP_ADDR(UP_ADDR), .UP_IN_WIN(UP_IN_WIN), .UP_DONE(UP_DONE), .UP_FWD(UP_FWD),
    .MA_EVT(MA_EVT), .MA_READ(MA_READ), .MA_POSTED(MA_POSTED), .UR_EVT(UR_EVT), .UR_READ(UR_READ),
    .ABT_DONE(ABT_DONE), .ABT_RDATA(ABT_RDATA), .UR_CPL(UR_CPL), .WR_DISCARD(WR_DISCARD),
    .ERR_SIG(ERR_SIG), .TGT_ABORT(TGT_ABORT), .IRQ(IRQ));
  pci_side_model i_pci_side_model (.CLK(CLK), .UP_REQ(UP_REQ), .UP_IO(UP_IO), .UP_ADDR(UP_ADDR),
    .UP_IN_WIN(UP_IN_WIN), .MA_EVT(MA_EVT), .MA_READ(MA_READ), .MA_POSTED(MA_POSTED), .UR_EVT(UR_EVT),
    .UR_READ(UR_READ));
  initial begin
    forever #10 CLK = ~CLK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one Avalon access, held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} <= {~wr, wr, a, d, 4'h1};
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    if (AVS_WAITREQUEST !== 1'b0) chk(32'h0000_0001, 32'h0000_0000);
    q = AVS_READDATA;
    {AVS_READ, AVS_WRITE, AVS_BYTEENABLE} <= 6'h00;
    AVS_WRITEDATA <= ~d;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic dn(input logic io, input logic [31:0] a, input logic win, input logic exp);
    @(posedge CLK);
    {DN_REQ, DN_IO, DN_ADDR, DN_IN_WIN} <= {1'b1, io, a, win};
    @(posedge CLK);
    {DN_REQ, DN_IO, DN_ADDR, DN_IN_WIN} <= {1'b0, ~io, ~a, ~win};
    #1 chk({DN_DONE, DN_FWD}, {1'b1, exp});
  endtask
  task automatic up(input logic io, input logic [31:0] a, input logic win, input logic exp);
    i_pci_side_model.up(io, a, win);
    #1 chk({UP_DONE, UP_FWD}, {1'b1, exp});
  endtask
  task automatic abt(input logic [3:0] ev, input logic [4:0] exp, input logic [31:0] data);
    i_pci_side_model.abt(ev[3], ev[2], ev[1], ev[0]);
    #1 chk({ABT_DONE, UR_CPL, WR_DISCARD, ERR_SIG, TGT_ABORT}, exp);
    chk(ABT_RDATA, data);
  endtask
  task automatic t_regs;
    rd(5'h00, 32'h0000_0000);
    rd(5'h04, 32'h0000_0000);
    rd(5'h08, 32'h0000_0000);
    rd(5'h10, 32'h0000_0000);
    wr(5'h00, 32'hFFFF_FFFF);
    rd(5'h00, 32'h0000_003C);
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14, 32'h0000_0000);
    rd(5'h0C, 32'h0000_0000);
    wr(5'h04, 32'hFFFF_FFFF);
    rd(5'h04, 32'h0000_0003);
    wr(5'h08, 32'hFFFF_FFFF);
    rd(5'h08, 32'h0000_0000);
    wr(5'h10, 32'hFFFF_FFFF);
    rd(5'h10, 32'h0000_000F);
    wr(5'h10, 32'h0000_0000);
    wr(5'h00, 32'h0000_0000);
  endtask
  task automatic t_abort;
    abt(4'b1010, 5'h10, 32'hFFFF_FFFF);
    abt(4'b1001, 5'h14, 32'h0000_0000);
    abt(4'b0110, 5'h10, 32'hFFFF_FFFF);
    abt(4'b0100, 5'h14, 32'h0000_0000);
    wr(5'h00, 32'h0000_0020);
    abt(4'b1000, 5'h18, 32'h0000_0000);
    abt(4'b1010, 5'h18, 32'h0000_0000);
    abt(4'b1001, 5'h1A, 32'h0000_0000);
    abt(4'b0110, 5'h11, 32'h0000_0000);
    wr(5'h00, 32'h0000_0000);
  endtask
  task automatic t_display;
    wr(5'h04, 32'h0000_0003);
    wr(5'h00, 32'h0000_0008);
    dn(1'b1, 32'h0000_03B0, 1'b0, 1'b1);
    dn(1'b1, 32'h0000_FFDF, 1'b0, 1'b1);
    dn(1'b1, 32'h0001_03B0, 1'b0, 1'b0);
    dn(1'b0, 32'h000A_0000, 1'b0, 1'b1);
    dn(1'b0, 32'h000C_0000, 1'b0, 1'b0);
    up(1'b0, 32'h000B_FFFF, 1'b0, 1'b0);
    up(1'b1, 32'h0000_03C0, 1'b0, 1'b0);
    wr(5'h00, 32'h0000_001C);
    dn(1'b1, 32'h0000_FFDF, 1'b0, 1'b0);
    dn(1'b1, 32'h0000_03C0, 1'b1, 1'b1);
    wr(5'h04, 32'h0000_0002);
    dn(1'b1, 32'h0000_03B0, 1'b0, 1'b0);
    dn(1'b0, 32'h000A_0000, 1'b0, 1'b1);
    wr(5'h04, 32'h0000_0001);
    dn(1'b0, 32'h000A_0000, 1'b0, 1'b0);
    wr(5'h00, 32'h0000_0010);
    dn(1'b1, 32'h0000_03C0, 1'b0, 1'b0);
    dn(1'b1, 32'h0000_03C0, 1'b1, 1'b1);
  endtask
  task automatic t_alias;
    wr(5'h04, 32'h0000_0003);
    wr(5'h00, 32'h0000_0004);
    dn(1'b1, 32'h0000_0100, 1'b1, 1'b0);
    dn(1'b1, 32'h0000_04FF, 1'b1, 1'b1);
    dn(1'b1, 32'h0001_0100, 1'b1, 1'b1);
    dn(1'b1, 32'h0000_0100, 1'b0, 1'b0);
    up(1'b1, 32'h0000_0100, 1'b1, 1'b1);
    up(1'b1, 32'h0000_0000, 1'b1, 1'b0);
    wr(5'h00, 32'h0000_0000);
    dn(1'b1, 32'h0000_0100, 1'b1, 1'b1);
  endtask
  task automatic t_irq;
    rd(5'h08, 32'h0000_000F);
    #1 chk(IRQ, 1'b0);
    wr(5'h10, 32'h0000_0001);
    #1 chk(IRQ, 1'b1);
    wr(5'h0C, 32'h0000_0001);
    #1 chk(IRQ, 1'b0);
    wr(5'h08, 32'h0000_0000);
    rd(5'h08, 32'h0000_000E);
    wr(5'h10, 32'h0000_0008);
    #1 chk(IRQ, 1'b1);
    wr(5'h0C, 32'h0000_000F);
    #1 chk(IRQ, 1'b0);
    rd(5'h08, 32'h0000_0000);
  endtask
  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    t_regs();
    t_abort();
    t_display();
    t_alias();
    t_irq();
    stop_test();
  end
endmodule
